/* File: verilog/pbg_top.sv */
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Purpose: single pulse generator built from sample points
// Assumes: APB slave on mclk, external clock on its own port
// Notes: times in ns; period, width, delay commit on the HI word
// Functional notes
// - a period of 40 ns to 100 s is accepted and clamped into that range.
// - a width of 10 ns to 99.999999999 s is accepted and the achieved width is readable.
// - a signed delay of at most the period less one point places the pulse after or before sync.
// - the waveform has 4 to 100000 points, none shorter than 10 ns.
// - short periods use the most points of 10 ns that fit, stretched to period over count.
// - width and delay are quantised to whole points.
// - above 1 ms the count is 100000 and the point is period over 100000.
// - a period change rescales actual width and delay, programmed values stay.
// - the frequency path keeps the count and only rescales the point, no shorter than 10 ns.
// - the set-up path recomputes the count, which falls with the period below 1 ms.
// - the sample clock is internal or external, the latter socket or system clock.
// - after external is chosen the internal clock runs on until the first external edge.
// - in external mode one point advances per external clock period.
// - sync starts with the first point and lasts a few points.
module pbg_top (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sample clock sources
	input wire logic ext_clk,
	input wire logic sys_clk_in,
	// to the output stage
	output logic pulse_out,
	output logic sync_out
);
	import pbg_pkg::*;

	// ========================================
	// register file
	logic [3:0] ctrl_q;
	logic [31:0] stage_q;
	logic [39:0] per_q;
	logic [39:0] wid_q;
	logic [39:0] dly_q;
	logic [16:0] cnt_q;
	logic [16:0] cold_q;
	logic [16:0] wpts_q;
	logic [17:0] dpts_q;
	logic resc_q;
	logic one_q;
	logic ext_act_q;
	logic idle;
	pbg_state_t st_q;
	logic wr;
	logic rd_map;
	logic [39:0] wr_time;
	logic [39:0] p_new;
	logic [39:0] p_floor;

	pbg_div_if dv ();

	// clamp a time into a range
	function automatic logic [39:0] clamp(input logic [39:0] v, lo, hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// magnitude of a signed value
	function automatic logic [39:0] mag(input logic [39:0] v);
		mag = v[39] ? (~v + 40'h00_0000_0001) : v;
	endfunction

	assign wr = psel & penable & pwrite & ce;
	assign pready = ce;
	assign wr_time = {pwdata[7:0], stage_q};
	assign p_new = clamp(wr_time, PER_MIN_NS, PER_MAX_NS);
	assign p_floor = 40'(cnt_q) * 40'(POINT_MIN_NS);

	// decode of mapped addresses
	always_comb
	begin
		unique case (paddr)
			A_CTRL, A_PER_LO, A_PER_HI, A_WID_LO, A_WID_HI, A_DLY_LO, A_DLY_HI,
			A_STAT, A_CNT, A_AWID, A_ADLY: rd_map = 1'b1;
			default: rd_map = 1'b0;
		endcase
	end

	assign pslverr = psel & penable & ~rd_map;

	// read data, registered-state views
	always_comb
	begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			A_CTRL: prdata = {28'h000_0000, ctrl_q};
			A_PER_LO: prdata = per_q[31:0];
			A_PER_HI: prdata = {24'h00_0000, per_q[39:32]};
			A_WID_LO: prdata = wid_q[31:0];
			A_WID_HI: prdata = {24'h00_0000, wid_q[39:32]};
			A_DLY_LO: prdata = dly_q[31:0];
			A_DLY_HI: prdata = {24'h00_0000, dly_q[39:32]};
			A_STAT: prdata = {30'h0000_0000, ext_act_q, ~idle};
			A_CNT: prdata = {15'h0000, cnt_q};
			A_AWID: prdata = {15'h0000, wpts_q};
			A_ADLY: prdata = {{14{dpts_q[17]}}, dpts_q};
			default: prdata = 32'h0000_0000;
		endcase
	end

	// control register and low word staging
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q <= CTRL_RST;
			stage_q <= 32'h0000_0000;
		end
		else if (wr)
		begin
			if (paddr == A_CTRL)
				ctrl_q <= pwdata[3:0];
			if (paddr == A_PER_LO || paddr == A_WID_LO || paddr == A_DLY_LO)
				stage_q <= pwdata;
		end
	end

	// ========================================
	// sequencer for count, width and delay
	logic [63:0] qn;
	logic [16:0] q17;
	logic [16:0] dlim;
	assign idle = (st_q == S_IDLE);
	assign qn = dv.quo;
	assign q17 = (qn > 64'(PTS_MAX)) ? PTS_MAX : qn[16:0];
	assign dlim = cnt_q - 17'h0_0001;

	// divider operands per state
	always_comb
	begin
		dv.num = '0;
		dv.den = 40'(POINT_MIN_NS);
		unique case (st_q)
			S_IDLE: dv.num = '0;
			S_CNT: dv.num = 64'(per_q);
			S_WID:
			begin
				dv.num = resc_q ? 64'(wpts_q) * 64'(cnt_q) : 64'(wid_q) * 64'(cnt_q);
				dv.den = resc_q ? 40'(cold_q) : per_q;
			end
			S_DLY:
			begin
				dv.num = resc_q ? 64'(mag(40'($signed(dpts_q)))) * 64'(cnt_q)
					: 64'(mag(dly_q)) * 64'(cnt_q);
				dv.den = resc_q ? 40'(cold_q) : per_q;
			end
		endcase
	end

	// commits from the bus and sequencing of the jobs
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= S_IDLE;
			per_q <= PER_RST;
			wid_q <= WID_RST;
			dly_q <= '0;
			cnt_q <= CNT_RST;
			cold_q <= CNT_RST;
			wpts_q <= WPTS_RST;
			dpts_q <= '0;
			resc_q <= 1'b0;
			one_q <= 1'b0;
			dv.start <= 1'b0;
		end
		else if (ce)
		begin
			dv.start <= 1'b0;
			unique case (st_q)
				S_IDLE:
				if (wr && paddr == A_PER_HI)
				begin
					if (ctrl_q[C_FRQ])
						per_q <= (p_new < p_floor) ? p_floor : p_new;
					else
					begin
						per_q <= p_new;
						cold_q <= cnt_q;
						resc_q <= 1'b1;
						one_q <= 1'b0;
						st_q <= S_CNT;
						dv.start <= 1'b1;
					end
				end
				else if (wr && paddr == A_WID_HI)
				begin
					wid_q <= clamp(wr_time, WID_MIN_NS, WID_MAX_NS);
					resc_q <= 1'b0;
					one_q <= 1'b1;
					st_q <= S_WID;
					dv.start <= 1'b1;
				end
				else if (wr && paddr == A_DLY_HI)
				begin
					dly_q <= wr_time;
					resc_q <= 1'b0;
					st_q <= S_DLY;
					dv.start <= 1'b1;
				end
				S_CNT:
				if (dv.done)
				begin
					// most 10 ns points that fit, capped at the maximum
					cnt_q <= (q17 < PTS_MIN) ? PTS_MIN : q17;
					st_q <= S_WID;
					dv.start <= 1'b1;
				end
				S_WID:
				if (dv.done)
				begin
					wpts_q <= (q17 == 17'h0_0000) ? 17'h0_0001
						: ((q17 > cnt_q) ? cnt_q : q17);
					st_q <= one_q ? S_IDLE : S_DLY;
					dv.start <= ~one_q;
				end
				S_DLY:
				if (dv.done)
				begin
					// magnitude held to one point short of the period
					if (resc_q ? dpts_q[17] : dly_q[39])
						dpts_q <= -18'($signed({1'b0, (q17 > dlim) ? dlim : q17}));
					else
						dpts_q <= {1'b0, (q17 > dlim) ? dlim : q17};
					st_q <= S_IDLE;
				end
			endcase
		end
	end

	pbg_div #(
		.NW(64),
		.DW(40)
	) u_div (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.dv(dv)
	);

	// ========================================
	// link side: each rising external edge flips a toggle
	logic ext_tog_q;
	always_ff @(posedge ext_clk or posedge rst)
	begin
		if (rst)
			ext_tog_q <= 1'b0;
		else
			ext_tog_q <= ~ext_tog_q;
	end

	// toggle and system clock pin brought into mclk
	logic [2:0] es_q;
	logic [2:0] ys_q;
	logic sel_edge;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			es_q <= 3'b000;
			ys_q <= 3'b000;
		end
		else if (ce)
		begin
			es_q <= {es_q[1:0], ext_tog_q};
			ys_q <= {ys_q[1:0], sys_clk_in};
		end
	end

	// edge of the chosen external source
	assign sel_edge = ctrl_q[C_SYS] ? (ys_q[1] & ~ys_q[2]) : (es_q[1] ^ es_q[2]);

	// hand over to the external source at its first edge
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			ext_act_q <= 1'b0;
		else if (ce)
		begin
			if (!ctrl_q[C_EXT])
				ext_act_q <= 1'b0;
			else if (sel_edge)
				ext_act_q <= 1'b1;
		end
	end

	// ========================================
	// internal synthesiser: period over count per point
	logic [39:0] acc_q;
	logic [40:0] acc_sum;
	logic int_adv;
	logic adv;
	assign acc_sum = {1'b0, acc_q} + 41'(cnt_q) * 41'(MCLK_PERIOD_NS);
	assign int_adv = (acc_sum >= {1'b0, per_q});
	assign adv = ext_act_q ? sel_edge : int_adv;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			acc_q <= '0;
		else if (ce)
		begin
			if (!ctrl_q[C_RUN] || ext_act_q)
				acc_q <= '0;
			else if (int_adv)
				acc_q <= 40'(acc_sum - {1'b0, per_q});
			else
				acc_q <= acc_sum[39:0];
		end
	end

	// point counter
	logic [16:0] pt_q;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			pt_q <= '0;
		else if (ce)
		begin
			if (!ctrl_q[C_RUN] || pt_q >= cnt_q)
				pt_q <= '0;
			else if (adv)
				pt_q <= (pt_q + 17'h0_0001 >= cnt_q) ? 17'h0_0000 : pt_q + 17'h0_0001;
		end
	end

	// ========================================
	// output levels relative to the sync point
	logic signed [18:0] rel0;
	logic signed [18:0] rel;
	assign rel0 = $signed({2'b00, pt_q}) - $signed({dpts_q[17], dpts_q});
	always_comb
	begin
		rel = rel0;
		if (rel0 < 0)
			rel = rel0 + $signed({2'b00, cnt_q});
		else if (rel0 >= $signed({2'b00, cnt_q}))
			rel = rel0 - $signed({2'b00, cnt_q});
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pulse_out <= 1'b0;
			sync_out <= 1'b0;
		end
		else if (ce)
		begin
			pulse_out <= ctrl_q[C_RUN] && (rel < $signed({2'b00, wpts_q}));
			sync_out <= ctrl_q[C_RUN] && (pt_q < SYNC_PTS);
		end
	end
endmodule

/* File: verilog/pbg_pkg.sv */
// Purpose: constants shared by the point based pulse generator
// Assumes: times held in whole ns, mclk at 200 MHz
// Notes: register offsets are byte addresses on APB
package pbg_pkg;
	// ========================================
	// timing
	localparam int MCLK_PERIOD_NS = 5;
	localparam int POINT_MIN_NS = 10;
	localparam logic [39:0] PER_MIN_NS = 40'h00_0000_0028;
	localparam logic [39:0] PER_MAX_NS = 40'h17_4876_e800;
	localparam logic [39:0] WID_MIN_NS = 40'h00_0000_000a;
	localparam logic [39:0] WID_MAX_NS = 40'h17_4876_e7ff;
	localparam logic [16:0] PTS_MIN = 17'h0_0004;
	localparam logic [16:0] PTS_MAX = 17'h1_86a0;
	localparam logic [16:0] SYNC_PTS = 17'h0_0002;
	// ========================================
	// reset values
	localparam logic [39:0] PER_RST = 40'h00_0001_86a0;
	localparam logic [39:0] WID_RST = 40'h00_0000_c350;
	localparam logic [16:0] CNT_RST = 17'h0_2710;
	localparam logic [16:0] WPTS_RST = 17'h0_1388;
	localparam logic [3:0] CTRL_RST = 4'h0;
	// ========================================
	// register map
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_PER_LO = 12'h004;
	localparam logic [11:0] A_PER_HI = 12'h008;
	localparam logic [11:0] A_WID_LO = 12'h00c;
	localparam logic [11:0] A_WID_HI = 12'h010;
	localparam logic [11:0] A_DLY_LO = 12'h014;
	localparam logic [11:0] A_DLY_HI = 12'h018;
	localparam logic [11:0] A_STAT = 12'h01c;
	localparam logic [11:0] A_CNT = 12'h020;
	localparam logic [11:0] A_AWID = 12'h024;
	localparam logic [11:0] A_ADLY = 12'h028;
	// control fields
	localparam int C_RUN = 0;
	localparam int C_EXT = 1;
	localparam int C_SYS = 2;
	localparam int C_FRQ = 3;
	// ========================================
	// sequencer states, gray along the path
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_CNT = 2'b01,
		S_WID = 2'b11,
		S_DLY = 2'b10
	} pbg_state_t;
endpackage

/* File: verilog/pbg_div_if.sv */
`timescale 1ns/1ps
// Purpose: request and answer of the shared divider
// Assumes: one request at a time
// Notes: start is a one cycle pulse, done likewise
interface pbg_div_if;
	logic start;
	logic [63:0] num;
	logic [39:0] den;
	logic busy;
	logic done;
	logic [63:0] quo;
	modport mst (output start, num, den, input busy, done, quo);
	modport slv (input start, num, den, output busy, done, quo);
endinterface

/* File: verilog/pbg_div.sv */
`timescale 1ns/1ps
// Purpose: serial restoring divider, one quotient bit per cycle
// Assumes: den nonzero, operands stable only at start
// Notes: done pulses NW+1 cycles after start
module pbg_div #(
	parameter int NW = 64,
	parameter int DW = 40
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// request port
	pbg_div_if.slv dv
);
	import pbg_pkg::*;
	logic [NW-1:0] n_q;
	logic [DW:0] r_q;
	logic [DW-1:0] d_q;
	logic [6:0] k_q;
	logic [DW:0] sh;
	// shift in the next numerator bit
	assign sh = {r_q[DW-1:0], n_q[NW-1]};
	assign dv.quo = n_q;
	assign dv.busy = (k_q != 7'h00);
	// iteration
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			n_q <= '0;
			r_q <= '0;
			d_q <= '0;
			k_q <= 7'h00;
			dv.done <= 1'b0;
		end
		else if (ce)
		begin
			dv.done <= 1'b0;
			if (dv.start)
			begin
				n_q <= dv.num;
				d_q <= dv.den;
				r_q <= '0;
				k_q <= 7'(NW);
			end
			else if (k_q != 7'h00)
			begin
				if (sh >= {1'b0, d_q})
				begin
					r_q <= sh - {1'b0, d_q};
					n_q <= {n_q[NW-2:0], 1'b1};
				end
				else
				begin
					r_q <= sh;
					n_q <= {n_q[NW-2:0], 1'b0};
				end
				k_q <= k_q - 7'h01;
				dv.done <= (k_q == 7'h01);
			end
		end
	end
endmodule

/* File: sim/pbg_top_props.sv */
// Purpose: port level checks of the pulse generator
// Assumes: one mclk domain, rst async active high
// Notes: bound to pbg_top below the module
`timescale 1ns/1ps
module pbg_top_props (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// sources and outputs
	input wire logic ext_clk,
	input wire logic sys_clk_in,
	input wire logic pulse_out,
	input wire logic sync_out
);
	import pbg_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ========================================
	// apb answer
	ready_ce_a: assert property (pready == ce)
		else $error("pready differs from ce");
	unmapped_err_a: assert property (psel && penable && paddr > A_ADLY |-> pslverr)
		else $error("no error on unmapped address");
	mapped_ok_a: assert property (psel && penable && paddr <= A_ADLY && paddr[1:0] == 2'b00
		|-> !pslverr) else $error("error on mapped address");
	unmapped_zero_a: assert property (psel && penable && !pwrite && paddr > A_ADLY
		|-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
	setup_noerr_a: assert property (!penable |-> !pslverr)
		else $error("error outside access phase");
	ctrl_stands_a: assert property (psel && !penable && !pwrite && paddr == A_CTRL
		|=> $stable(prdata)) else $error("control read data moved");
	// ========================================
	// outputs
	sync_width_a: assert property ($rose(sync_out) |-> sync_out [*4])
		else $error("sync shorter than two points");
	freeze_out_a: assert property (!ce |=> $stable(pulse_out) && $stable(sync_out))
		else $error("outputs moved while frozen");
endmodule
bind pbg_top pbg_top_props u_props (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ext_clk(ext_clk), .sys_clk_in(sys_clk_in),
	.pulse_out(pulse_out), .sync_out(sync_out));

/* File: sim/pbg_clk_src.sv */
// Purpose: far side sample clock sources, socket and system clock
// Assumes: each source stands low while disabled
// Notes: phases unrelated to mclk
`timescale 1ns/1ps
module pbg_clk_src (
	// enables from the bench
	input wire logic ext_en,
	input wire logic sys_en,
	// clocks to the device
	output logic ext_clk,
	output logic sys_clk_in
);
	// ========================================
	// socket clock, 48 ns period chosen here
	initial
	begin
		ext_clk = 1'b0;
		#3.7;
		forever #24 ext_clk = ext_en ? ~ext_clk : 1'b0;
	end
	// shared system clock, 60 ns period
	initial
	begin
		sys_clk_in = 1'b0;
		#11.3;
		forever #30 sys_clk_in = sys_en ? ~sys_clk_in : 1'b0;
	end
endmodule

/* File: sim/tb_top.sv */
// Purpose: self checking bench of the pulse generator
// Assumes: mclk 5 ns, socket clock 48 ns, system clock 60 ns
// Notes: timing is measured on sync and pulse edges
`timescale 1ns/1ps
module tb_top;
	import pbg_pkg::*;
	localparam logic [39:0] YES = 40'h00_0000_0001;
	logic mclk, rst, ce, psel, penable, pwrite, pready, pslverr;
	logic ext_clk, sys_clk_in, pulse_out, sync_out, ext_en, sys_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [39:0] w;
	logic [39:0] per_tab [5] = '{40'h2e_90ed_d000, 40'h00_0098_9680, 40'h00_0000_001e,
		40'h00_0000_00c8, 40'h00_0000_00c7};
	int n_mismatch, num_checks, n_sync, k;
	realtime ts, sp, tp, poff, pw;
	pbg_top DUT (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_clk(ext_clk), .sys_clk_in(sys_clk_in),
		.pulse_out(pulse_out), .sync_out(sync_out));
	pbg_clk_src u_src (.ext_en(ext_en), .sys_en(sys_en), .ext_clk(ext_clk),
		.sys_clk_in(sys_clk_in));
	// ========================================
	// clock and edge timing
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge sync_out)
	begin
		sp = $realtime - ts;
		ts = $realtime;
		n_sync++;
	end
	always @(posedge pulse_out)
	begin
		tp = $realtime;
		poff = tp - ts;
	end
	always @(negedge pulse_out) pw = $realtime - tp;
	// ========================================
	// bench tasks and expectations
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic wr_q, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr_q;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [39:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk({8'h00, r}, e);
	endtask
	// low word then high word, then wait for the sequencer
	task automatic wr(input logic [11:0] a, input logic [39:0] v);
		int c;
		apb(1'b1, a, v[31:0]);
		apb(1'b1, a + 12'h004, {24'h00_0000, v[39:32]});
		c = 0;
		do
		begin
			apb(1'b0, A_STAT, 32'h0000_0000);
			c++;
		end
		while (r[0] !== 1'b0 && c < 500);
		if (c >= 500) n_mismatch++;
	endtask
	task automatic syncs(input int n);
		int n0, c;
		n0 = n_sync;
		c = 0;
		while (n_sync < n0 + n && c < 2000)
		begin
			@(posedge mclk);
			c++;
		end
		if (c >= 2000) n_mismatch++;
	endtask
	function automatic logic [39:0] cnt_of(input logic [39:0] p);
		logic [39:0] q;
		q = ((p < PER_MIN_NS) ? PER_MIN_NS : p) / 40'h00_0000_000a;
		return (q > 40'(PTS_MAX)) ? 40'(PTS_MAX) : q;
	endfunction
	function automatic logic [39:0] pts(input logic [39:0] v, input logic [39:0] c,
		input logic [39:0] p);
		logic [79:0] q;
		q = (80'(v) * 80'(c)) / 80'(p);
		if (q == 80'(0)) q = 80'(1);
		if (q > 80'(c)) q = 80'(c);
		return q[39:0];
	endfunction
	function automatic logic [39:0] near(input realtime a, input realtime e);
		return 40'(a > e - 8.0 && a < e + 8.0);
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ========================================
	// main sequence
	initial
	begin
		k = $urandom(32'h87d3);
		{rst, ce, psel, penable, pwrite, paddr, pwdata} = {2'b11, 47'h0};
		{ext_en, sys_en, n_mismatch, num_checks, n_sync} = '0;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		rd(A_CTRL, 40'(CTRL_RST));
		rd(A_CNT, 40'(CNT_RST));
		rd(A_AWID, 40'(WPTS_RST));
		rd(12'h030, 40'h00_0000_0000);
		wr(A_PER_LO, 40'h00_0000_ea60);
		rd(A_AWID, 40'h00_0000_0bb8);
		rd(A_WID_LO, WID_RST);
		foreach (per_tab[i])
		begin
			wr(A_PER_LO, per_tab[i]);
			rd(A_CNT, cnt_of(per_tab[i]));
		end
		apb(1'b1, A_CTRL, 32'h0000_0001);
		repeat (4)
		begin
			w = 40'($urandom_range(10, 199));
			wr(A_WID_LO, w);
			rd(A_AWID, pts(w, 40'h00_0000_0013, 40'h00_0000_00c7));
		end
		wr(A_PER_LO, 40'h00_0000_00c8);
		wr(A_WID_LO, 40'h00_0000_0032);
		wr(A_DLY_LO, 40'h00_0000_001e);
		rd(A_ADLY, 40'h00_0000_0003);
		syncs(3);
		chk(near(sp, 200.0), YES);
		chk(near(poff, 30.0), YES);
		chk(near(pw, 50.0), YES);
		wr(A_DLY_LO, 40'hff_ffff_ffe2);
		syncs(3);
		chk(near(poff, 170.0), YES);
		fork
			rd(A_CNT, 40'h00_0000_0014);
			begin
				@(posedge mclk);
				ce <= 1'b0;
				repeat (3) @(posedge mclk);
				ce <= 1'b1;
			end
		join
		apb(1'b1, A_CTRL, 32'h0000_0009);
		wr(A_PER_LO, 40'h00_0000_0190);
		rd(A_CNT, 40'h00_0000_0014);
		syncs(3);
		chk(near(sp, 400.0), YES);
		wr(A_PER_LO, 40'h00_0000_0064);
		rd(A_PER_LO, 40'h00_0000_00c8);
		apb(1'b1, A_CTRL, 32'h0000_0003);
		syncs(3);
		chk(near(sp, 200.0), YES);
		rd(A_STAT, 40'h00_0000_0000);
		ext_en <= 1'b1;
		syncs(3);
		chk(near(sp, 960.0), YES);
		rd(A_STAT, 40'h00_0000_0002);
		apb(1'b1, A_CTRL, 32'h0000_0007);
		sys_en <= 1'b1;
		syncs(3);
		chk(near(sp, 1200.0), YES);
		final_report();
	end
	// watchdog
	initial
	begin
		#400us;
		n_mismatch++;
		final_report();
	end
endmodule
